// ### rtl/tmc_map.svh
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

// Register indexes; byte address is four times the index
`define TMC_IDX_CONTROL      5'h05
`define TMC_IDX_INTERRUPT_STATUS_ENABLE       5'h07
`define TMC_IDX_COUNT_LOW    5'h0b
`define TMC_IDX_COUNT_HIGH   5'h0c
`define TMC_IDX_EVT_STATUS   5'h10
`define TMC_IDX_EVT_CLEAR    5'h11
`define TMC_IDX_EVT_ENABLE   5'h12

// Control register fields
`define TMC_CTRL_IRQ_EDGE    7
`define TMC_CTRL_CLK_EDGE    6
`define TMC_CTRL_SRC         5
`define TMC_CTRL_PS_MSB      4
`define TMC_CTRL_PS_LSB      1

// Interrupt status/enable fields
`define TMC_INT_PERIPH       7
`define TMC_INT_FLAG_LSB     4

// Reset values
`define TMC_CTRL_RESET       7'h00
`define TMC_ENABLE_RESET     4'h0
`define TMC_EVT_EN_RESET     3'h0
`define TMC_COUNT_RESET      16'h0000
`define TMC_PRESC_RESET      8'h00

// Counting constants
`define TMC_COUNT_MAX        16'hffff
`define TMC_PRESCALE_MAX     8'hff
`define TMC_Q_LAST           2'h3

`endif

// ### rtl/tmc_pkg.sv
package tmc_pkg;

  typedef enum logic [1:0] {
    TMC_BUS_IDLE   = 2'b01,
    TMC_BUS_ANSWER = 2'b10
  } tmc_bus_state_t;

  typedef logic [7:0] tmc_byte_t;

endpackage

// ### rtl/tmc_timer.sv
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "tmc_map.svh"

module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_clock_pin,
  input  wire logic        ext_irq_pin,
  input  wire logic        master_clear_pin_n,
  input  wire logic        wdt_reset,
  input  wire logic        sleep_mode,
  input  wire logic        peripheral_irq_flag,
  output logic             irq,
  output logic             wake_request
);

  tmc_bus_state_t bus_state;
  tmc_byte_t      rd_byte;
  logic [4:0]     idx;
  logic           bus_wr;
  logic [6:0]     timer_control;
  logic [3:0]     int_enable;
  logic [2:0]     flags;
  logic [2:0]     evt_enable;
  logic [2:0]     flag_set;
  logic [15:0]    count_value;
  logic [7:0]     prescaler;
  logic [7:0]     pre_last_val;
  logic [1:0]     q_phase;
  logic           q_tick;
  logic           clk_s1;
  logic           clk_s2;
  logic           clk_prev;
  logic           irq_s1;
  logic           irq_s2;
  logic           irq_prev;
  logic           master_clear_pin_s1;
  logic           master_clear_pin_s2;
  logic           other_reset;
  logic           ext_clk_edge;
  logic           ext_irq_edge;
  logic           src_tick;
  logic           pre_last;
  logic           count_step;
  logic           cnt_wr;
  logic           ovf_event;
  logic           ext_irq_edge_select;
  logic           ext_clock_edge_select;
  logic           clock_source_select;
  logic [3:0]     prescale_select;

  assign ext_irq_edge_select   = timer_control[`TMC_CTRL_IRQ_EDGE - 1];
  assign ext_clock_edge_select = timer_control[`TMC_CTRL_CLK_EDGE - 1];
  assign clock_source_select   = timer_control[`TMC_CTRL_SRC - 1];
  assign prescale_select       = timer_control[`TMC_CTRL_PS_MSB - 1:`TMC_CTRL_PS_LSB - 1];

  // Pin synchronisers; third stage only for edge detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_s1   <= 1'b0;
      clk_s2   <= 1'b0;
      clk_prev <= 1'b0;
      irq_s1   <= 1'b0;
      irq_s2   <= 1'b0;
      irq_prev <= 1'b0;
      master_clear_pin_s1  <= 1'b1;
      master_clear_pin_s2  <= 1'b1;
    end else if (clk_en) begin
      clk_s1   <= ext_clock_pin;
      clk_s2   <= clk_s1;
      clk_prev <= clk_s2;
      irq_s1   <= ext_irq_pin;
      irq_s2   <= irq_s1;
      irq_prev <= irq_s2;
      master_clear_pin_s1  <= master_clear_pin_n;
      master_clear_pin_s2  <= master_clear_pin_s1;
    end
  end

  assign other_reset = !master_clear_pin_s2 || wdt_reset;

  assign ext_clk_edge = ext_clock_edge_select ? (clk_s2 && !clk_prev) : (!clk_s2 && clk_prev);
  assign ext_irq_edge = ext_irq_edge_select ? (irq_s2 && !irq_prev) : (!irq_s2 && irq_prev);

  // Quarter-cycle phase, one instruction tick per four clocks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q_phase <= 2'h0;
    end else if (clk_en && !sleep_mode) begin
      q_phase <= q_phase + 2'h1;
    end
  end

  assign q_tick = (q_phase == `TMC_Q_LAST) && !sleep_mode;

  assign src_tick = clock_source_select ? q_tick : ext_clk_edge;

  always_comb begin
    if (prescale_select[3]) begin
      pre_last_val = `TMC_PRESCALE_MAX;
    end else begin
      pre_last_val = (8'h01 << prescale_select[2:0]) - 8'h01;
    end
  end

  assign pre_last   = prescaler == pre_last_val;
  assign count_step = src_tick && pre_last;
  assign idx        = avs_address[6:2];
  assign bus_wr     = (bus_state == TMC_BUS_ANSWER) && avs_write && clk_en && avs_byteenable[0];
  assign cnt_wr     = bus_wr && (idx == `TMC_IDX_COUNT_LOW || idx == `TMC_IDX_COUNT_HIGH);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prescaler <= `TMC_PRESC_RESET;
    end else if (clk_en) begin
      if (other_reset || cnt_wr) begin
        prescaler <= `TMC_PRESC_RESET;
      end else if (src_tick) begin
        prescaler <= pre_last ? `TMC_PRESC_RESET : prescaler + 8'h01;
      end
    end
  end

  // byte-writable count; write beats the increment
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_value <= `TMC_COUNT_RESET;
    end else if (clk_en) begin
      if (other_reset) begin
        count_value <= count_value;
      end else if (cnt_wr && idx == `TMC_IDX_COUNT_LOW) begin
        count_value[7:0] <= avs_writedata[7:0];
      end else if (cnt_wr) begin
        count_value[15:8] <= avs_writedata[7:0];
      end else if (count_step) begin
        count_value <= count_value + 16'h0001;
      end
    end
  end

  assign ovf_event = count_step && !cnt_wr && (count_value == `TMC_COUNT_MAX);

  // edge flag set; no tick-based flag in sleep
  assign flag_set = {ext_clk_edge, ovf_event, ext_irq_edge};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_control <= `TMC_CTRL_RESET;
    end else if (clk_en) begin
      if (other_reset) begin
        timer_control <= `TMC_CTRL_RESET;
      end else if (bus_wr && idx == `TMC_IDX_CONTROL) begin
        timer_control <= avs_writedata[7:1];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_enable <= `TMC_ENABLE_RESET;
      evt_enable <= `TMC_EVT_EN_RESET;
    end else if (clk_en) begin
      if (other_reset) begin
        int_enable <= `TMC_ENABLE_RESET;
        evt_enable <= `TMC_EVT_EN_RESET;
      end else if (bus_wr && idx == `TMC_IDX_INTERRUPT_STATUS_ENABLE) begin
        int_enable <= avs_writedata[3:0];
      end else if (bus_wr && idx == `TMC_IDX_EVT_ENABLE) begin
        evt_enable <= avs_writedata[2:0];
      end
    end
  end

  // Sticky flags: set wins over bus clears; other reset wins over set
  for (genvar i = 0; i < 3; i++) begin : g_flag
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        flags[i] <= 1'b0;
      end else if (clk_en) begin
        if (other_reset) begin
          flags[i] <= 1'b0;
        end else if (flag_set[i]) begin
          flags[i] <= 1'b1;
        end else if (bus_wr && idx == `TMC_IDX_INTERRUPT_STATUS_ENABLE) begin
          flags[i] <= avs_writedata[`TMC_INT_FLAG_LSB + i];
        end else if (bus_wr && idx == `TMC_IDX_EVT_CLEAR && avs_writedata[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(flags & evt_enable);

  assign wake_request = sleep_mode &&
    (|({peripheral_irq_flag, flags} & int_enable));

  // Read mux; unmapped reads as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `TMC_IDX_CONTROL:    rd_byte = {timer_control, 1'b0};
      `TMC_IDX_INTERRUPT_STATUS_ENABLE:     rd_byte = {peripheral_irq_flag, flags, int_enable};
      `TMC_IDX_COUNT_LOW:  rd_byte = count_value[7:0];
      `TMC_IDX_COUNT_HIGH: rd_byte = count_value[15:8];
      `TMC_IDX_EVT_STATUS: rd_byte = {5'h00, flags};
      `TMC_IDX_EVT_ENABLE: rd_byte = {5'h00, evt_enable};
      default:             rd_byte = 8'h00;
    endcase
  end

  // One wait cycle, then answer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state <= TMC_BUS_IDLE;
    end else if (clk_en) begin
      unique case (bus_state)
        TMC_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= TMC_BUS_ANSWER;
          end
        end
        TMC_BUS_ANSWER: begin
          bus_state <= TMC_BUS_IDLE;
        end
        default: begin
          bus_state <= TMC_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && bus_state == TMC_BUS_IDLE && avs_read) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  assign avs_waitrequest = !(bus_state == TMC_BUS_ANSWER && clk_en);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_ctrl_read;
    clk_en && bus_state == TMC_BUS_IDLE && avs_read && idx == `TMC_IDX_CONTROL;
  endsequence

  sequence s_irq_rise;
    clk_en && irq_s2 && !irq_prev && ext_irq_edge_select && !other_reset;
  endsequence

  sequence s_irq_fall;
    clk_en && !irq_s2 && irq_prev && !ext_irq_edge_select && !other_reset;
  endsequence

  a_ctrl_bit_zero: assert property (
    s_ctrl_read |=> (avs_readdata[0] == 1'b0) && (avs_readdata[31:8] == 24'h00_0000))
    else $error("Control read shows bit 0 or upper bits set");

  a_other_reset_clears: assert property (
    (clk_en && other_reset) |=> (timer_control == 7'h00) && (int_enable == 4'h0)
      && (flags == 3'h0))
    else $error("Other reset did not clear control and status");

  a_count_kept_reset: assert property (
    (clk_en && other_reset) |=> $stable(count_value))
    else $error("Count changed during other reset");

  a_overflow_flag_set: assert property (
    (clk_en && !other_reset && count_step && !cnt_wr && count_value == 16'hffff)
      |=> flags[1] && count_value == 16'h0000)
    else $error("Rollover did not set overflow flag");

  a_sleep_no_tick: assert property (
    (clk_en && sleep_mode && clock_source_select && !cnt_wr && !other_reset)
      |=> $stable(count_value) && $stable(q_phase))
    else $error("Instruction clock counted during sleep");

  a_ext_clock_flag: assert property (
    (clk_en && ext_clk_edge && !other_reset) |=> flags[2])
    else $error("External clock edge did not set its flag");

  a_ext_irq_edge: assert property (
    (s_irq_rise or s_irq_fall) |=> flags[0])
    else $error("Selected interrupt edge did not set its flag");

  a_count_step_one: assert property (
    (clk_en && count_step && !cnt_wr && !other_reset)
      |=> count_value == $past(count_value) + 16'h0001)
    else $error("Count did not advance by one on prescaler wrap");

  a_prescale_advance: assert property (
    (clk_en && src_tick && !pre_last && !cnt_wr && !other_reset)
      |=> prescaler == $past(prescaler) + 8'h01 && $stable(count_value))
    else $error("Prescaler did not advance or count moved early");

  a_ctrl_write_lands: assert property (
    (bus_wr && idx == 5'h05 && !other_reset) |=> timer_control == $past(avs_writedata[7:1]))
    else $error("Control write at index 05h lost");

  a_wake_enabled: assert property (
    (sleep_mode && flags[2] && int_enable[2]) |-> wake_request)
    else $error("Enabled external clock flag did not wake");

  a_bus_answer_time: assert property (
    (clk_en && bus_state == TMC_BUS_IDLE && (avs_read || avs_write)) ##1 clk_en
      |-> !avs_waitrequest)
    else $error("Bus answer late");

  sequence s_low_write;
    bus_wr && idx == `TMC_IDX_COUNT_LOW && !other_reset;
  endsequence

  a_low_byte_write: assert property (
    s_low_write |=> count_value[7:0] == $past(avs_writedata[7:0]))
    else $error("Low count byte write lost");

  a_byte_enable_gate: assert property (
    (clk_en && bus_state == TMC_BUS_ANSWER && avs_write && !avs_byteenable[0] && !other_reset)
      |=> $stable(timer_control))
    else $error("Write without byte enable changed control");

  a_freeze_hold: assert property (
    !clk_en |=> $stable(count_value) && $stable(prescaler) && $stable(bus_state))
    else $error("State moved while clock enable low");

  a_wake_awake_low: assert property (
    !sleep_mode |-> !wake_request)
    else $error("Wake request raised while awake");

endmodule

// ### verif/tmc_pin_model.sv
`timescale 1ns/1ns

module tmc_pin_model (
  input  wire logic ref_clk,
  output logic      ext_clock_pin,
  output logic      ext_irq_pin
);
  initial begin
    ext_clock_pin = 1'b0;
    ext_irq_pin   = 1'b0;
  end

  task automatic set_clock(input logic lvl);
    @(posedge ref_clk);
    ext_clock_pin <= lvl;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic set_irq(input logic lvl);
    @(posedge ref_clk);
    ext_irq_pin <= lvl;
    repeat (6) @(posedge ref_clk);
  endtask

  // one rising and one falling edge each
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      set_clock(1'b1);
      set_clock(1'b0);
    end
  endtask
endmodule

// ### verif/tb_timer_counter_16bit_prescaled.sv
`timescale 1ns/1ns

module tb_timer_counter_16bit_prescaled;
  import tmc_pkg::*;
  logic        ref_clk;
  logic        resetn;
  logic        clk_en;
  logic [3:0]  avs_byteenable;
  logic [6:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_clock_pin;
  logic        ext_irq_pin;
  logic        master_clear_pin_n;
  logic        wdt_reset;
  logic        sleep_mode;
  logic        peripheral_irq_flag;
  logic        irq;
  logic        wake_request;
  int          miscompares;
  int          tests_run;

  tmc_timer i_tmc_timer (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_clock_pin(ext_clock_pin),
    .ext_irq_pin(ext_irq_pin), .master_clear_pin_n(master_clear_pin_n),
    .wdt_reset(wdt_reset), .sleep_mode(sleep_mode),
    .peripheral_irq_flag(peripheral_irq_flag), .irq(irq), .wake_request(wake_request));

  tmc_pin_model i_tmc_pin_model (.ref_clk(ref_clk), .ext_clock_pin(ext_clock_pin),
    .ext_irq_pin(ext_irq_pin));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_byte(input tmc_byte_t got, input tmc_byte_t exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t byte got %h want %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [6:0] a, input tmc_byte_t d,
                     output tmc_byte_t q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 50) begin
        miscompares++;
        $display("[FAIL] %0t bus timeout", $time);
        report_and_stop();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input tmc_byte_t d);
    tmc_byte_t q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [6:0] a, input tmc_byte_t exp);
    tmc_byte_t q;
    bus(1'b0, a, 8'h00, q);
    check_byte(q, exp);
  endtask

  task automatic set_count(input tmc_byte_t hi, input tmc_byte_t lo);
    wr(7'h30, hi);
    wr(7'h2c, lo);
  endtask

  task automatic t_reset_regs();
    rd_chk(7'h14, 8'h00);
    rd_chk(7'h1c, 8'h00);
    wr(7'h14, 8'hff);
    rd_chk(7'h14, 8'hfe);
    rd_chk(7'h7c, 8'h00);
    peripheral_irq_flag <= 1'b1;
    rd_chk(7'h1c, 8'h80);
    peripheral_irq_flag <= 1'b0;
  endtask

  task automatic t_edges();
    wr(7'h14, 8'h40);
    set_count(8'h00, 8'h00);
    i_tmc_pin_model.set_clock(1'b1);
    rd_chk(7'h2c, 8'h01);
    i_tmc_pin_model.set_clock(1'b0);
    rd_chk(7'h2c, 8'h01);
    wr(7'h14, 8'h00);
    wr(7'h2c, 8'h00);
    i_tmc_pin_model.set_clock(1'b1);
    rd_chk(7'h2c, 8'h00);
    i_tmc_pin_model.set_clock(1'b0);
    rd_chk(7'h2c, 8'h01);
  endtask

  task automatic t_prescale();
    logic [3:0] codes [10];
    int ratio;
    codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
    foreach (codes[i]) begin
      ratio = codes[i][3] ? 256 : (1 << codes[i]);
      wr(7'h14, 8'h40 | {3'h0, codes[i], 1'b0});
      set_count(8'h00, 8'h00);
      i_tmc_pin_model.pulses(2 * ratio - 1);
      rd_chk(7'h2c, 8'h01);
      i_tmc_pin_model.pulses(1);
      rd_chk(7'h2c, 8'h02);
    end
  endtask

  task automatic t_overflow();
    wr(7'h14, 8'h40);
    wr(7'h44, 8'h07);
    wr(7'h1c, 8'h00);
    wr(7'h48, 8'h02);
    set_count(8'hff, 8'hff);
    i_tmc_pin_model.pulses(1);
    rd_chk(7'h2c, 8'h00);
    rd_chk(7'h30, 8'h00);
    rd_chk(7'h1c, 8'h60);
    rd_chk(7'h40, 8'h06);
    rd_chk(7'h48, 8'h02);
    rd_chk(7'h44, 8'h00);
    check_bit(irq, 1'b1);
    wr(7'h48, 8'h00);
    repeat (2) @(posedge ref_clk);
    check_bit(irq, 1'b0);
    wr(7'h48, 8'h02);
    wr(7'h44, 8'h02);
    repeat (2) @(posedge ref_clk);
    check_bit(irq, 1'b0);
    rd_chk(7'h40, 8'h04);
  endtask

  task automatic t_irq_sleep();
    tmc_byte_t q;
    wr(7'h1c, 8'h01);
    wr(7'h14, 8'h80);
    sleep_mode <= 1'b1;
    i_tmc_pin_model.set_irq(1'b1);
    rd_chk(7'h1c, 8'h11);
    check_bit(wake_request, 1'b1);
    wr(7'h1c, 8'h01);
    wr(7'h14, 8'h00);
    i_tmc_pin_model.set_irq(1'b0);
    rd_chk(7'h1c, 8'h11);
    wr(7'h1c, 8'h01);
    i_tmc_pin_model.set_irq(1'b1);
    rd_chk(7'h1c, 8'h01);
    check_bit(wake_request, 1'b0);
    wr(7'h14, 8'h20);
    set_count(8'h00, 8'h00);
    repeat (40) @(posedge ref_clk);
    i_tmc_pin_model.pulses(2);
    rd_chk(7'h2c, 8'h00);
    sleep_mode <= 1'b0;
    wr(7'h2c, 8'h00);
    repeat (40) @(posedge ref_clk);
    bus(1'b0, 7'h2c, 8'h00, q);
    check_bit(q inside {[8'h09:8'h0c]}, 1'b1);
    wr(7'h14, 8'h00);
  endtask

  task automatic t_gating();
    tmc_byte_t q;
    wr(7'h14, 8'h20);
    avs_byteenable <= 4'he;
    wr(7'h14, 8'h40);
    avs_byteenable <= 4'hf;
    rd_chk(7'h14, 8'h20);
    wr(7'h2c, 8'h00);
    clk_en <= 1'b0;
    repeat (40) @(posedge ref_clk);
    check_bit(avs_waitrequest, 1'b1);
    clk_en <= 1'b1;
    bus(1'b0, 7'h2c, 8'h00, q);
    check_bit(q inside {[8'h00:8'h01]}, 1'b1);
    wr(7'h14, 8'h00);
  endtask

  task automatic t_other_reset();
    wr(7'h14, 8'h80);
    set_count(8'h12, 8'h34);
    @(posedge ref_clk);
    wdt_reset <= 1'b1;
    @(posedge ref_clk);
    wdt_reset <= 1'b0;
    rd_chk(7'h14, 8'h00);
    rd_chk(7'h2c, 8'h34);
    wr(7'h14, 8'hc0);
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    master_clear_pin_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk(7'h14, 8'h00);
    rd_chk(7'h30, 8'h12);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    avs_byteenable = 4'hf;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    master_clear_pin_n = 1'b1;
    wdt_reset = 1'b0;
    sleep_mode = 1'b0;
    peripheral_irq_flag = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset_regs();
    t_edges();
    t_prescale();
    t_overflow();
    t_irq_sleep();
    t_gating();
    t_other_reset();
    report_and_stop();
  end
endmodule
